// ==== core/sbrl_loader.v ====
// serial boot RAM loader: mode handshake, command, password, header, data, jump
`timescale 1ns/1ps
`include "sbrl_defines.vh"

// ==========================================================
module sbrl_loader (
	input  wire        CLK_SYS,       // system clock, 10 MHz
	input  wire        RESET_N,       // synchronous reset, active low
	input  wire        RX_VALID,      // one-cycle strobe: byte received
	input  wire [7:0]  RX_DATA,       // received byte
	input  wire        RX_ERROR,      // receive error seen on this byte
	input  wire        RATE_OK,       // mode byte rate is reproducible
	input  wire [7:0]  RATE_DIV,      // divider measured from mode byte
	input  wire        TX_READY,      // channel accepts the transmit byte
	input  wire [95:0] FLASH_PW,      // stored password, byte 0 in low bits
	output reg         TX_VALID,      // transmit byte waiting
	output reg  [7:0]  TX_DATA,       // serial_data_buffer contents
	output reg         RX_ENABLE,     // receive_enable_bit
	output reg         CLOCKED_MODE,  // external_shift_clock, rising edge
	output reg         BAUD_LOAD,     // baud_divider_control programmed
	output reg  [7:0]  BAUD_DIV,      // baud divider value
	output reg         RAM_WE,        // one-cycle RAM byte write
	output reg  [31:0] RAM_ADDR,      // RAM byte address
	output reg  [7:0]  RAM_WDATA,     // RAM byte data
	output reg         JUMP,          // one-cycle branch request
	output reg  [31:0] JUMP_ADDR,     // branch target
	output reg         ISA32,         // run target in 32-bit mode
	output reg         HALTED         // session aborted silently
);

	// ======================================================
	// states
	localparam [10:0] S_MODE = 11'h001;
	localparam [10:0] S_ECHO = 11'h002;
	localparam [10:0] S_CMD  = 11'h004;
	localparam [10:0] S_PW   = 11'h008;
	localparam [10:0] S_HDR  = 11'h010;
	localparam [10:0] S_DATA = 11'h020;
	localparam [10:0] S_DCK  = 11'h040;
	localparam [10:0] S_SEND = 11'h080;
	localparam [10:0] S_JUMP = 11'h100;
	localparam [10:0] S_RUN  = 11'h200;
	localparam [10:0] S_HALT = 11'h400;

	reg  [10:0] state;
	reg  [10:0] ret_state;
	reg  [3:0]  cmd_hi;
	reg  [7:0]  echo_byte;
	reg  [7:0]  sum;
	reg         err_acc;
	reg         pw_bad;
	reg  [15:0] cnt;
	reg  [31:0] load_addr;
	reg  [15:0] byte_cnt;

	wire        byte_err;
	wire        any_err;
	wire [7:0]  next_sum;
	wire [7:0]  pw_byte;
	wire [11:0] pw_same;
	wire        pw_weak;
	wire        addr_ok;
	wire [7:0]  ack_rx;
	wire [7:0]  ack_fail;
	wire [7:0]  ack_ok;
	wire [31:0] cnt_wide;

	// errors only count in async mode; clocked mode has no error ack
	assign byte_err = RX_ERROR & ~CLOCKED_MODE;
	assign any_err  = err_acc | byte_err;
	assign next_sum = sum + RX_DATA;
	assign pw_byte  = FLASH_PW[{cnt[3:0], 3'b000} +: 8];
	assign addr_ok  = (load_addr >= `SBRL_RAM_LO) && (load_addr <= `SBRL_RAM_HI);
	assign cnt_wide = {16'h0000, cnt};

	// ack codes: nibble of last accepted command, bit3 rx error, bit0 fail
	assign ack_rx   = {cmd_hi, `SBRL_ACK_RXERR};
	assign ack_fail = {cmd_hi, `SBRL_ACK_FAIL};
	assign ack_ok   = {cmd_hi, `SBRL_ACK_OK};

	// ======================================================
	// uniform stored password check, one compare per byte
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_same
			assign pw_same[gi] = FLASH_PW[gi*8 +: 8] == FLASH_PW[7:0];
		end
	endgenerate
	assign pw_weak = (&pw_same) && (FLASH_PW[7:0] != `SBRL_BYTE_FF);

	// ======================================================
	// protocol sequencer
	always @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			state        <= S_MODE;
			ret_state    <= S_MODE;
			cmd_hi       <= `SBRL_CMDHI_RST;
			echo_byte    <= `SBRL_BYTE_RST;
			sum          <= `SBRL_BYTE_RST;
			err_acc      <= 1'b0;
			pw_bad       <= 1'b0;
			cnt          <= `SBRL_CNT_RST;
			load_addr    <= `SBRL_WORD_RST;
			byte_cnt     <= `SBRL_CNT_RST;
			TX_VALID     <= 1'b0;
			TX_DATA      <= `SBRL_BYTE_RST;
			RX_ENABLE    <= 1'b0;
			CLOCKED_MODE <= 1'b0;
			BAUD_LOAD    <= 1'b0;
			BAUD_DIV     <= `SBRL_BAUD_RST;
			RAM_WE       <= 1'b0;
			RAM_ADDR     <= `SBRL_WORD_RST;
			RAM_WDATA    <= `SBRL_BYTE_RST;
			JUMP         <= 1'b0;
			JUMP_ADDR    <= `SBRL_WORD_RST;
			ISA32        <= 1'b0;
			HALTED       <= 1'b0;
		end else begin
			// strobes last one cycle
			BAUD_LOAD <= 1'b0;
			RAM_WE    <= 1'b0;
			JUMP      <= 1'b0;
			case (state)
				// receiver stays off during the mode byte
				S_MODE: begin
					if (RX_VALID) begin
						echo_byte <= RX_DATA;
						if (RX_DATA == `SBRL_MODE_ASYNC && RATE_OK) begin
							BAUD_DIV  <= RATE_DIV;
							BAUD_LOAD <= 1'b1;
							RX_ENABLE <= 1'b1;
							state     <= S_ECHO;
						end else if (RX_DATA == `SBRL_MODE_CLKD) begin
							CLOCKED_MODE <= 1'b1;
							RX_ENABLE    <= 1'b1;
							state        <= S_ECHO;
						end else begin
							HALTED <= 1'b1;
							state  <= S_HALT;
						end
					end
				end
				// echo is loaded one cycle after the receiver is on
				S_ECHO: begin
					TX_DATA   <= echo_byte;
					TX_VALID  <= 1'b1;
					ret_state <= S_CMD;
					state     <= S_SEND;
				end
				// command byte
				// cmd_hi moves only on an accepted command, so error acks carry the last good one
				S_CMD: begin
					if (RX_VALID) begin
						TX_VALID <= 1'b1;
						state    <= S_SEND;
						sum      <= `SBRL_BYTE_RST;
						err_acc  <= 1'b0;
						pw_bad   <= 1'b0;
						cnt      <= `SBRL_CNT_RST;
						if (byte_err) begin
							TX_DATA   <= ack_rx;
							ret_state <= S_CMD;
						end else if (RX_DATA == `SBRL_CMD_RAM) begin
							cmd_hi    <= RX_DATA[7:4];
							TX_DATA   <= RX_DATA;
							ret_state <= S_PW;
						end else begin
							TX_DATA   <= ack_fail;
							ret_state <= S_CMD;
						end
					end
				end
				// twelve password bytes then their checksum
				S_PW: begin
					if (RX_VALID) begin
						sum     <= next_sum;
						err_acc <= any_err;
						cnt     <= cnt + 16'h0001;
						if (cnt != `SBRL_PW_LEN) begin
							if (RX_DATA != pw_byte)
								pw_bad <= 1'b1;
						end else begin
							TX_VALID  <= 1'b1;
							state     <= S_SEND;
							ret_state <= S_CMD;
							if (any_err)
								TX_DATA <= ack_rx;
							else if (next_sum != `SBRL_BYTE_RST || pw_bad || pw_weak)
								TX_DATA <= ack_fail;
							else begin
								TX_DATA   <= ack_ok;
								ret_state <= S_HDR;
							end
						end
					end
				end
				// address, count, checksum
				// an address outside the RAM window fails like a bad checksum
				S_HDR: begin
					if (RX_VALID) begin
						sum     <= next_sum;
						err_acc <= any_err;
						cnt     <= cnt + 16'h0001;
						if (cnt < 16'h0004)
							load_addr <= {load_addr[23:0], RX_DATA};
						else if (cnt < `SBRL_HDR_LEN)
							byte_cnt <= {byte_cnt[7:0], RX_DATA};
						else begin
							TX_VALID  <= 1'b1;
							state     <= S_SEND;
							ret_state <= S_CMD;
							if (any_err)
								TX_DATA <= ack_rx;
							else if (next_sum != `SBRL_BYTE_RST || !addr_ok)
								TX_DATA <= ack_fail;
							else begin
								TX_DATA   <= ack_ok;
								ret_state <= (byte_cnt == `SBRL_CNT_RST) ? S_DCK : S_DATA;
							end
						end
					end
				end
				// payload bytes into RAM, one write per byte
				S_DATA: begin
					if (RX_VALID) begin
						sum       <= next_sum;
						err_acc   <= any_err;
						RAM_WE    <= 1'b1;
						RAM_ADDR  <= load_addr + cnt_wide;
						RAM_WDATA <= RX_DATA;
						cnt       <= cnt + 16'h0001;
						if (cnt == byte_cnt - 16'h0001)
							state <= S_DCK;
					end
				end
				// data checksum
				S_DCK: begin
					if (RX_VALID) begin
						TX_VALID  <= 1'b1;
						state     <= S_SEND;
						ret_state <= S_CMD;
						if (any_err)
							TX_DATA <= ack_rx;
						else if (next_sum != `SBRL_BYTE_RST)
							TX_DATA <= ack_fail;
						else begin
							TX_DATA   <= ack_ok;
							ret_state <= S_JUMP;
						end
					end
				end
				// hold the byte until the channel takes it
				// bytes arriving meanwhile are dropped, so the host must wait for each ack
				// no timeout here: a host that never clocks the byte out stalls the loader
				S_SEND: begin
					if (TX_READY) begin
						TX_VALID <= 1'b0;
						state    <= ret_state;
						sum      <= `SBRL_BYTE_RST;
						err_acc  <= 1'b0;
						cnt      <= `SBRL_CNT_RST;
					end
				end
				// branch only after the good ack left
				S_JUMP: begin
					JUMP      <= 1'b1;
					JUMP_ADDR <= load_addr;
					ISA32     <= 1'b1;
					state     <= S_RUN;
				end
				S_RUN: state <= S_RUN;
				S_HALT: state <= S_HALT;
				default: state <= S_MODE;
			endcase
		end
	end

endmodule // sbrl_loader

// ==== pkg/sbrl_defines.vh ====
// constants of the serial boot RAM loader
`ifndef SBRL_DEFINES_VH
`define SBRL_DEFINES_VH

// ==========================================================
// mode bytes and command codes
`define SBRL_MODE_ASYNC  8'h86
`define SBRL_MODE_CLKD   8'h30
`define SBRL_CMD_RAM     8'h10

// ==========================================================
// acknowledge layout: upper nibble, rx error bit, fail bit
`define SBRL_ACK_ERR_BIT 3
`define SBRL_ACK_FAIL_BIT 0
`define SBRL_ACK_RXERR   4'h8
`define SBRL_ACK_FAIL    4'h1
`define SBRL_ACK_OK      4'h0

// ==========================================================
// password, header and RAM window
`define SBRL_PW_BASE     32'h0000_03f4
`define SBRL_PW_LEN      16'h000c
`define SBRL_HDR_LEN     16'h0006
`define SBRL_BYTE_FF     8'hff
`define SBRL_RAM_LO      32'hfffd_6000
`define SBRL_RAM_HI      32'hfffd_efff

// ==========================================================
// reset values
`define SBRL_BAUD_RST    8'h00
`define SBRL_CMDHI_RST   4'h0
`define SBRL_BYTE_RST    8'h00
`define SBRL_WORD_RST    32'h0000_0000
`define SBRL_CNT_RST     16'h0000

`endif

// ==== verif/sbrl_host.sv ====
// host controller model on the boot byte link
`timescale 1ns/1ps
module sbrl_host (
	input  wire       clk,          // system clock
	input  wire       tx_valid,     // device byte waiting
	input  wire [7:0] tx_data,      // device byte
	output reg        rx_valid = 0, // byte strobe
	output reg  [7:0] rx_data = 0,  // byte to device
	output reg        rx_error = 0, // corrupt byte flag
	output reg        tx_ready = 0  // host takes byte
);
	// ==========
	// one strobe per byte; idle data is scrambled so it is never reused
	task send(input [7:0] b, input e);
		@(posedge clk);
		#1 rx_valid = 1;
		rx_data = b;
		rx_error = e;
		@(posedge clk);
		#1 rx_valid = 0;
		rx_data = ~b;
		rx_error = 0;
	endtask
	// wait for the reply, stall w cycles, then clock it out
	task get(output [7:0] a, input int w);
		int n;
		n = 0;
		while (!tx_valid && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		// every stall step lands one unit after the edge, like every other drive
		repeat (w) begin
			@(posedge clk);
			#1 n++;
		end
		a = tx_valid ? tx_data : 8'hxx;
		tx_ready = 1;
		@(posedge clk);
		#1 tx_ready = 0;
	endtask
endmodule // sbrl_host

// ==== verif/sbrl_monitor.sv ====
// port checker for the serial boot RAM loader
`timescale 1ns/1ps
module sbrl_monitor (
	input wire       CLK_SYS,      // clock
	input wire       RESET_N,      // reset, active low
	input wire [7:0] RX_DATA,      // received byte
	input wire [7:0] RATE_DIV,     // measured divider
	input wire       TX_VALID,     // byte waiting
	input wire [7:0] TX_DATA,      // byte to send
	input wire       TX_READY,     // channel takes byte
	input wire       RX_ENABLE,    // receiver on
	input wire       BAUD_LOAD,    // divider written
	input wire [7:0] BAUD_DIV,     // divider value
	input wire       CLOCKED_MODE, // external clock mode
	input wire       JUMP,         // branch pulse
	input wire       ISA32,        // 32-bit mode
	input wire       HALTED        // silent abort
);
	// ==========
	// one domain, so one clock and one reset for all
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	a_ack_spare_bits:
		assert property (TX_VALID && TX_DATA != 8'h86 |-> TX_DATA[2:1] == 2'b00)
		else $error("ack spare bits set");
	a_tx_held:
		assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("tx byte not held");
	a_tx_taken:
		assert property (TX_VALID && TX_READY |=> !TX_VALID)
		else $error("tx byte not released");
	a_rx_before_echo:
		assert property ($rose(TX_VALID) |-> RX_ENABLE)
		else $error("receiver off at tx load");
	a_baud_load:
		assert property (BAUD_LOAD |-> BAUD_DIV == $past(RATE_DIV) && $past(RX_DATA) == 8'h86)
		else $error("divider load wrong");
	a_async_echo:
		assert property (BAUD_LOAD |=> TX_VALID && TX_DATA == 8'h86 && !BAUD_LOAD)
		else $error("async echo missing");
	a_clocked_echo:
		assert property ($rose(CLOCKED_MODE) |-> ##[0:2] (TX_VALID && TX_DATA == 8'h30))
		else $error("clocked echo missing");
	a_jump_pulse:
		assert property (JUMP |-> ISA32 ##1 !JUMP)
		else $error("jump pulse wrong");
	a_halt_quiet:
		assert property (HALTED |-> !TX_VALID && !RX_ENABLE)
		else $error("halted but talking");
endmodule // sbrl_monitor

bind sbrl_loader sbrl_monitor mon (.*);

// ==== verif/tb_sbrl_loader.sv ====
// self-checking bench for the serial boot RAM loader
`timescale 1ns/1ps
`include "sbrl_defines.vh"
module tb_sbrl_loader;
	reg         CLK_SYS  = 0;     // bench clock
	reg         RESET_N  = 0;     // synchronous reset
	reg         RATE_OK  = 1;     // rate check result
	reg  [7:0]  RATE_DIV = 8'h5a; // measured divider
	reg  [95:0] FLASH_PW = 96'ha0a1_a2a3_a4a5_a6a7_a8a9_aaab;
	wire        RX_VALID, RX_ERROR, TX_READY, TX_VALID, RX_ENABLE, CLOCKED_MODE;
	wire        BAUD_LOAD, RAM_WE, JUMP, ISA32, HALTED;
	wire [7:0]  RX_DATA, TX_DATA, BAUD_DIV, RAM_WDATA;
	wire [31:0] RAM_ADDR, JUMP_ADDR;
	int         fail_count = 0, n_tests = 0, slow = 0;
	reg  [7:0]  bb [0:15];
	reg  [31:0] ra [$];
	reg  [7:0]  rd [$];
	reg  [31:0] ja = 0;
	// rows: rx error, command byte, expected ack
	reg  [16:0] rows [0:3] = '{17'h02001, 17'h05501, 17'h13008, 17'h0ff01};
	sbrl_loader uut (.CLK_SYS, .RESET_N, .RX_VALID, .RX_DATA, .RX_ERROR, .RATE_OK, .RATE_DIV,
		.TX_READY, .FLASH_PW, .TX_VALID, .TX_DATA, .RX_ENABLE, .CLOCKED_MODE, .BAUD_LOAD,
		.BAUD_DIV, .RAM_WE, .RAM_ADDR, .RAM_WDATA, .JUMP, .JUMP_ADDR, .ISA32, .HALTED);
	sbrl_host h (.clk(CLK_SYS), .tx_valid(TX_VALID), .tx_data(TX_DATA), .rx_valid(RX_VALID),
		.rx_data(RX_DATA), .rx_error(RX_ERROR), .tx_ready(TX_READY));
	// ==========
	// clock, RAM write log and branch capture
	always #50 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) if (RAM_WE) begin
		ra.push_back(RAM_ADDR);
		rd.push_back(RAM_WDATA);
	end
	always @(posedge CLK_SYS) if (JUMP) ja <= JUMP_ADDR;
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task report_and_stop;
		$display("%0d checks, %0d wrong", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task rst;
		#1 RESET_N = 0;
		repeat (3) @(posedge CLK_SYS);
		#1 RESET_N = 1;
	endtask
	task ck(input [7:0] e);
		reg [7:0] a;
		h.get(a, slow);
		chk("ack", a, e);
	endtask
	// block with its checksum; ei marks a byte sent as corrupt
	task blk(input int n, input int ei, input [7:0] fix);
		reg [7:0] s;
		s = 0;
		for (int i = 0; i < n; i++) begin
			h.send(bb[i], i == ei);
			s = s + bb[i];
		end
		h.send(8'h00 - s + fix, 1'b0);
	endtask
	task pwt(input int ei, input [7:0] fix, input [7:0] x, input [7:0] e);
		h.send(`SBRL_CMD_RAM, 1'b0);
		ck(8'h10);
		for (int i = 0; i < 12; i++) bb[i] = FLASH_PW[8*i +: 8];
		bb[2] = bb[2] ^ x;
		blk(12, ei, fix);
		ck(e);
	endtask
	task enter(input [31:0] ad);
		pwt(-1, 8'h00, 8'h00, 8'h10);
		{bb[0], bb[1], bb[2], bb[3], bb[4], bb[5]} = {ad, 16'h0003};
		blk(6, -1, 0);
	endtask
	task dat(input [7:0] fix, input [7:0] e);
		bb[0] = 8'h11;
		bb[1] = 8'h22;
		bb[2] = 8'h33;
		blk(3, -1, fix);
		ck(e);
	endtask
	// watchdog well beyond the expected run length
	initial begin
		#3000000 fail_count++;
		report_and_stop;
	end
	// ==========
	// main sequence
	initial begin
		rst;
		chk("idle", {TX_VALID, RX_ENABLE, HALTED, JUMP}, 0);
		h.send(`SBRL_MODE_ASYNC, 1'b0);
		ck(8'h86);
		chk("divider", BAUD_DIV, 8'h5a);
		for (int i = 0; i < 4; i++) begin
			h.send(rows[i][15:8], rows[i][16]);
			ck(rows[i][7:0]);
		end
		$display("command table done");
		pwt(-1, 8'h00, 8'h04, 8'h11);
		pwt(5, 8'h00, 8'h00, 8'h18);
		slow = 3;
		pwt(-1, 8'h01, 8'h00, 8'h11);
		enter(32'hfffd_f000);
		ck(8'h11);
		enter(32'hfffd_5fff);
		ck(8'h11);
		enter(32'hfffd_6000);
		ck(8'h10);
		dat(8'h01, 8'h11);
		ra.delete();
		rd.delete();
		enter(32'hfffd_6000);
		ck(8'h10);
		dat(8'h00, 8'h10);
		chk("writes", ra.size(), 3);
		for (int i = 0; i < 3; i++) begin
			chk("addr", ra[i], 32'hfffd_6000 + i);
			chk("data", rd[i], 8'h11 * (i + 1));
		end
		repeat (4) @(posedge CLK_SYS);
		chk("jump", ja, 32'hfffd_6000);
		chk("isa", ISA32, 1);
		$display("transfer done");
		rst;
		h.send(`SBRL_MODE_CLKD, 1'b0);
		ck(8'h30);
		chk("clocked", CLOCKED_MODE, 1);
		h.send(8'h10, 1'b1);
		ck(8'h10);
		FLASH_PW = {12{8'h33}};
		for (int i = 0; i < 12; i++) bb[i] = 8'h33;
		blk(12, 5, 0);
		ck(8'h11);
		$display("clocked mode done");
		rst;
		RATE_OK = 0;
		h.send(8'h86, 1'b0);
		repeat (20) @(posedge CLK_SYS);
		chk("halt", {HALTED, TX_VALID}, 2'b10);
		$display("halt done");
		report_and_stop;
	end
endmodule // tb_sbrl_loader
